// ===== design/msrm_register_map.sv
// register bank and serial port of the optical motion sensor
`timescale 1ns/1ps
`default_nettype none

module msrm_register_map
    import msrm_pkg::*;
#(
    parameter logic [7:0] PRODUCT_ID  = 8'h5c,  // arbitrary value
    parameter logic [7:0] REVISION_ID = 8'h13   // arbitrary value
) (
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    input  wire logic        sclk_i,
    input  wire logic        chip_select_n_i,
    input  wire logic        mosi_i,
    output var  logic        miso_o,
    input  wire logic        frame_i,
    input  wire logic [11:0] motion_dx_i,
    input  wire logic [11:0] motion_dy_i,
    input  wire logic [8:0]  surface_features_i,
    input  wire logic [15:0] shutter_i,
    input  wire logic [7:0]  brightest_pixel_i,
    input  wire logic [7:0]  pixel_sum_high_i,
    input  wire logic [7:0]  darkest_pixel_i,
    input  wire logic [7:0]  pixel_grabber_i,
    output var  logic        motion_flag_o,
    output var  logic        grab_restart_o,
    output logic      [7:0]  sensor_control_o,
    output logic      [7:0]  run_idle_delay_o,
    output logic      [7:0]  idle1_interval_o,
    output logic      [7:0]  idle1_delay_o,
    output logic      [7:0]  idle2_interval_o,
    output logic      [7:0]  idle2_delay_o,
    output logic      [7:0]  idle3_interval_o,
    output logic      [7:0]  tuning_control_o,
    output logic      [7:0]  lamp_control_o,
    output logic      [7:0]  interrupt_pin_control_o,
    output logic      [7:0]  idle_mode_config_o
);

    ////////////////////////////////////////////////////////////////////////
    // declarations

    logic [2:0]  bit_pos;
    logic        data_ph;
    logic        rd_acc;
    logic        burst_on;
    logic [2:0]  byte_idx;
    logic [6:0]  shift_q;
    logic [7:0]  in_byte;
    logic [7:0]  addr_word;
    logic [7:0]  wr_word;
    logic        addr_tgl;
    logic        wr_tgl;

    logic [SYNC_STAGES-1:0] addr_sync;
    logic [SYNC_STAGES-1:0] wr_sync;
    logic        addr_ev;
    logic        wr_ev;
    logic        rd_ev;
    logic [6:0]  acc_addr;
    logic        soft_rst;
    logic        rst;

    logic [7:0]  cfg [CFG_N];
    logic [7:0]  out_buf [BURST_LEN];
    logic [7:0]  next_out_buf [BURST_LEN];
    logic [11:0] acc_x;
    logic [11:0] acc_y;
    logic [11:0] next_acc_x;
    logic [11:0] next_acc_y;
    logic [3:0]  hold_x;
    logic [3:0]  hold_y;
    logic        hit_x;
    logic        hit_y;
    logic        clr_x;
    logic        clr_y;
    logic        clr_status;
    logic        twelve_bit;

    logic [7:0]  surface_quality;
    logic [7:0]  shutter_high;
    logic [7:0]  shutter_low;
    logic [7:0]  brightest_pixel;
    logic [7:0]  pixel_sum_high;
    logic [7:0]  darkest_pixel;

    ////////////////////////////////////////////////////////////////////////
    // link side, clocked by the host's serial clock

    assign in_byte = {shift_q, mosi_i};

    // frame state restarts whenever chip select rises
    always_ff @(posedge sclk_i or posedge chip_select_n_i) begin
        if (chip_select_n_i) begin
            bit_pos  <= 3'h0;
            data_ph  <= 1'b0;
            rd_acc   <= 1'b0;
            burst_on <= 1'b0;
            byte_idx <= 3'h0;
            shift_q  <= 7'h00;
        end else begin
            shift_q <= in_byte[6:0];
            bit_pos <= bit_pos + 3'h1;
            if (bit_pos == 3'h7) begin
                if (!data_ph) begin
                    data_ph  <= 1'b1;
                    rd_acc   <= !in_byte[WRITE_BIT];
                    burst_on <= !in_byte[WRITE_BIT]
                        && (in_byte[6:0] == A_BURST_READ_PORT);
                end else if (burst_on) begin
                    // burst holds the port until chip select rises
                    if (byte_idx != 3'h7) begin
                        byte_idx <= byte_idx + 3'h1;
                    end
                end else begin
                    data_ph <= 1'b0;
                end
            end
        end
    end

    // toggles must survive chip select, so only the main reset clears them
    always_ff @(posedge sclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            addr_word <= 8'h00;
            wr_word   <= 8'h00;
            addr_tgl  <= 1'b0;
            wr_tgl    <= 1'b0;
        end else if (!chip_select_n_i && bit_pos == 3'h7) begin
            if (!data_ph) begin
                addr_word <= in_byte;
                addr_tgl  <= ~addr_tgl;
            end else if (!rd_acc) begin
                wr_word <= in_byte;
                wr_tgl  <= ~wr_tgl;
            end
        end
    end

    // out_buf is quasi-static: it changes only while the host waits
    always_ff @(negedge sclk_i or posedge chip_select_n_i) begin
        if (chip_select_n_i) begin
            miso_o <= 1'b0;
        end else if (data_ph && rd_acc) begin
            miso_o <= out_buf[byte_idx][~bit_pos];
        end else begin
            miso_o <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // crossing into the core clock

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            addr_sync <= '0;
            wr_sync   <= '0;
        end else begin
            addr_sync <= {addr_sync[SYNC_STAGES-2:0], addr_tgl};
            wr_sync   <= {wr_sync[SYNC_STAGES-2:0], wr_tgl};
        end
    end

    assign addr_ev  = addr_sync[SYNC_STAGES-1] ^ addr_sync[SYNC_STAGES-2];
    assign wr_ev    = wr_sync[SYNC_STAGES-1] ^ wr_sync[SYNC_STAGES-2];
    assign rd_ev    = addr_ev && !addr_word[WRITE_BIT];
    assign acc_addr = addr_word[6:0];
    assign rst      = !resetn_i || soft_rst;

    // soft reset command acts one cycle after the write lands
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            soft_rst <= 1'b0;
        end else begin
            soft_rst <= wr_ev && acc_addr == A_SOFT_RESET_CMD
                && wr_word == SOFT_RESET_KEY;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration registers

    for (genvar g = 0; g < CFG_N; g++) begin : g_cfg
        always_ff @(posedge clk_i) begin
            if (rst) begin
                cfg[g] <= CFG_RST[g];
            end else if (wr_ev && acc_addr == CFG_ADDR[g]) begin
                cfg[g] <= wr_word;
            end
        end
    end

    assign sensor_control_o        = cfg[CI_SENSOR];
    assign run_idle_delay_o        = cfg[CI_RUN_IDLE];
    assign idle1_interval_o        = cfg[CI_IDLE1_INT];
    assign idle1_delay_o           = cfg[CI_IDLE1_DLY];
    assign idle2_interval_o        = cfg[CI_IDLE2_INT];
    assign idle2_delay_o           = cfg[CI_IDLE2_DLY];
    assign idle3_interval_o        = cfg[CI_IDLE3_INT];
    assign tuning_control_o        = cfg[CI_TUNING];
    assign lamp_control_o          = cfg[CI_LAMP];
    assign interrupt_pin_control_o = cfg[CI_IRQ_PIN];
    assign idle_mode_config_o      = cfg[CI_IDLE_CFG];
    assign twelve_bit = cfg[CI_SENSOR][TWELVE_BIT_MODE];

    always_ff @(posedge clk_i) begin
        if (rst) begin
            grab_restart_o <= 1'b0;
        end else begin
            grab_restart_o <= wr_ev && acc_addr == A_PIXEL_GRABBER;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // image statistics, refreshed once per frame

    always_ff @(posedge clk_i) begin
        if (rst) begin
            surface_quality <= RST_SURFACE_QUALITY;
            shutter_high    <= RST_SHUTTER_HIGH;
            shutter_low     <= RST_SHUTTER_LOW;
            brightest_pixel <= RST_BRIGHTEST_PIXEL;
            pixel_sum_high  <= RST_PIXEL_SUM_HIGH;
            darkest_pixel   <= RST_DARKEST_PIXEL;
        end else if (frame_i) begin
            // clamp rather than wrap when the count runs high
            if (surface_features_i[8:1] > SURFACE_QUAL_MAX) begin
                surface_quality <= SURFACE_QUAL_MAX;
            end else begin
                surface_quality <= surface_features_i[8:1];
            end
            shutter_high    <= shutter_i[15:8];
            shutter_low     <= shutter_i[7:0];
            brightest_pixel <= brightest_pixel_i;
            pixel_sum_high  <= pixel_sum_high_i;
            darkest_pixel   <= darkest_pixel_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read decode

    function automatic logic [7:0] reg_read(input logic [6:0] a,
                                            input logic live);
        logic [7:0] v;
        v = 8'h00;
        if (a == A_PRODUCT_IDENTITY) begin
            v = PRODUCT_ID;
        end else if (a == A_SILICON_REVISION) begin
            v = REVISION_ID;
        end else if (a == A_MOTION_FLAG_STATUS) begin
            v = {motion_flag_o, 7'h00};
        end else if (a == A_X_DELTA_LOW) begin
            v = acc_x[7:0];
        end else if (a == A_Y_DELTA_LOW) begin
            v = acc_y[7:0];
        end else if (a == A_SURFACE_QUALITY) begin
            v = surface_quality;
        end else if (a == A_SHUTTER_HIGH) begin
            v = shutter_high;
        end else if (a == A_SHUTTER_LOW) begin
            v = shutter_low;
        end else if (a == A_BRIGHTEST_PIXEL) begin
            v = brightest_pixel;
        end else if (a == A_PIXEL_SUM_HIGH) begin
            v = pixel_sum_high;
        end else if (a == A_DARKEST_PIXEL) begin
            v = darkest_pixel;
        end else if (a == A_PIXEL_GRABBER) begin
            v = pixel_grabber_i;
        end else if (a == A_XY_DELTA_UPPER) begin
            // a burst snapshots live nibbles, a lone read the held ones
            v = live ? {acc_x[11:8], acc_y[11:8]}
                     : {hold_x, hold_y};
        end else if (a == A_REVISION_COMPLEMENT) begin
            v = ~REVISION_ID;
        end else begin
            for (int i = 0; i < CFG_N; i++) begin
                if (a == CFG_ADDR[i]) begin
                    v = cfg[i];
                end
            end
        end
        return v;
    endfunction : reg_read

    function automatic logic [6:0] burst_next(input logic [6:0] a);
        logic [6:0] n;
        n = a + 7'h01;
        if (a == A_Y_DELTA_LOW) begin
            n = twelve_bit ? A_XY_DELTA_UPPER : A_SURFACE_QUALITY;
        end else if (a == A_XY_DELTA_UPPER) begin
            n = A_SURFACE_QUALITY;
        end
        return n;
    endfunction : burst_next

    // the whole burst is latched at once: bytes follow with no gap
    always_comb begin
        logic [6:0] ba;
        ba = cfg[CI_BURST_SEL][6:0];
        hit_x = 1'b0;
        hit_y = 1'b0;
        for (int i = 0; i < BURST_LEN; i++) begin
            next_out_buf[i] = 8'h00;
        end
        if (acc_addr == A_BURST_READ_PORT) begin
            for (int i = 0; i < BURST_LEN; i++) begin
                next_out_buf[i] = reg_read(ba, 1'b1);
                hit_x = hit_x || ba == A_X_DELTA_LOW;
                hit_y = hit_y || ba == A_Y_DELTA_LOW;
                ba = burst_next(ba);
            end
        end else begin
            next_out_buf[0] = reg_read(acc_addr, 1'b0);
            hit_x = acc_addr == A_X_DELTA_LOW;
            hit_y = acc_addr == A_Y_DELTA_LOW;
        end
    end

    always_ff @(posedge clk_i) begin
        for (int i = 0; i < BURST_LEN; i++) begin
            if (rst) begin
                out_buf[i] <= 8'h00;
            end else if (rd_ev) begin
                out_buf[i] <= next_out_buf[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // motion accumulation

    function automatic logic [11:0] sat_add(input logic [11:0] a,
                                            input logic [11:0] b);
        logic [12:0] s;
        s = {a[11], a} + {b[11], b};
        if (s[12] != s[11]) begin
            return s[12] ? 12'h800 : 12'h7ff;
        end
        return s[11:0];
    endfunction : sat_add

    assign clr_status = wr_ev && acc_addr == A_MOTION_FLAG_STATUS;
    assign clr_x = (rd_ev && hit_x) || clr_status;
    assign clr_y = (rd_ev && hit_y) || clr_status;

    // new motion lands on top of the cleared value, so none is lost
    assign next_acc_x = sat_add(clr_x ? 12'h000 : acc_x,
                                frame_i ? motion_dx_i : 12'h000);
    assign next_acc_y = sat_add(clr_y ? 12'h000 : acc_y,
                                frame_i ? motion_dy_i : 12'h000);

    always_ff @(posedge clk_i) begin
        if (rst) begin
            acc_x <= 12'h000;
            acc_y <= 12'h000;
        end else begin
            acc_x <= next_acc_x;
            acc_y <= next_acc_y;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst) begin
            hold_x <= 4'h0;
            hold_y <= 4'h0;
        end else begin
            if (clr_status) begin
                hold_x <= 4'h0;
                hold_y <= 4'h0;
            end else begin
                if (rd_ev && hit_x) begin
                    hold_x <= acc_x[11:8];
                end
                if (rd_ev && hit_y) begin
                    hold_y <= acc_y[11:8];
                end
            end
        end
    end

    // set beats clear; the flag drops once both counts are empty
    always_ff @(posedge clk_i) begin
        if (rst) begin
            motion_flag_o <= 1'b0;
        end else if (frame_i
                     && (motion_dx_i != 12'h000
                         || motion_dy_i != 12'h000)) begin
            motion_flag_o <= 1'b1;
        end else if (clr_status) begin
            motion_flag_o <= 1'b0;
        end else if (next_acc_x == 12'h000
                     && next_acc_y == 12'h000) begin
            motion_flag_o <= 1'b0;
        end
    end

endmodule : msrm_register_map

`default_nettype wire

// ===== design/msrm_pkg.sv
// constants of the motion sensor register map
package msrm_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register addresses
    localparam logic [6:0] A_PRODUCT_IDENTITY    = 7'h00;
    localparam logic [6:0] A_SILICON_REVISION    = 7'h01;
    localparam logic [6:0] A_MOTION_FLAG_STATUS  = 7'h02;
    localparam logic [6:0] A_X_DELTA_LOW         = 7'h03;
    localparam logic [6:0] A_Y_DELTA_LOW         = 7'h04;
    localparam logic [6:0] A_SURFACE_QUALITY     = 7'h05;
    localparam logic [6:0] A_SHUTTER_HIGH        = 7'h06;
    localparam logic [6:0] A_SHUTTER_LOW         = 7'h07;
    localparam logic [6:0] A_BRIGHTEST_PIXEL     = 7'h08;
    localparam logic [6:0] A_PIXEL_SUM_HIGH      = 7'h09;
    localparam logic [6:0] A_DARKEST_PIXEL       = 7'h0a;
    localparam logic [6:0] A_PIXEL_GRABBER       = 7'h0b;
    localparam logic [6:0] A_XY_DELTA_UPPER      = 7'h0c;
    localparam logic [6:0] A_SOFT_RESET_CMD      = 7'h3a;
    localparam logic [6:0] A_REVISION_COMPLEMENT = 7'h3f;
    localparam logic [6:0] A_BURST_READ_PORT     = 7'h63;

    ////////////////////////////////////////////////////////////////////////
    // plain read/write configuration registers
    localparam int CFG_N = 12;
    localparam int CI_SENSOR = 0, CI_RUN_IDLE = 1, CI_IDLE1_INT = 2;
    localparam int CI_IDLE1_DLY = 3, CI_IDLE2_INT = 4, CI_IDLE2_DLY = 5;
    localparam int CI_IDLE3_INT = 6, CI_TUNING = 7, CI_LAMP = 8;
    localparam int CI_IRQ_PIN = 9, CI_BURST_SEL = 10, CI_IDLE_CFG = 11;
    localparam logic [6:0] CFG_ADDR [CFG_N] = '{
        7'h0d, 7'h0e, 7'h0f, 7'h10, 7'h11, 7'h12,
        7'h13, 7'h22, 7'h40, 7'h41, 7'h42, 7'h45};
    localparam logic [7:0] CFG_RST [CFG_N] = '{
        8'h01, 8'h08, 8'h01, 8'h1f, 8'h09, 8'h2f,
        8'h31, 8'h00, 8'h00, 8'h40, 8'h03, 8'h00};

    ////////////////////////////////////////////////////////////////////////
    // reset values of the image statistics
    localparam logic [7:0] RST_SURFACE_QUALITY = 8'h00;
    localparam logic [7:0] RST_SHUTTER_HIGH    = 8'h00;
    localparam logic [7:0] RST_SHUTTER_LOW     = 8'h64;
    localparam logic [7:0] RST_BRIGHTEST_PIXEL = 8'hd0;
    localparam logic [7:0] RST_PIXEL_SUM_HIGH  = 8'h80;
    localparam logic [7:0] RST_DARKEST_PIXEL   = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // fields, keys and limits
    localparam int         WRITE_BIT        = 7;
    localparam int         MOTION_FLAG_BIT  = 7;
    localparam int         TWELVE_BIT_MODE  = 7;
    localparam logic [7:0] SURFACE_QUAL_MAX = 8'hb4;
    localparam logic [7:0] SOFT_RESET_KEY   = 8'h5a;
    localparam int         BURST_LEN        = 8;
    localparam int         SYNC_STAGES      = 3;

endpackage : msrm_pkg

// ===== sim/msrm_host_model.sv
// serial host model driving the sensor's four-wire port
`timescale 1ns/1ps
`default_nettype none
module msrm_host_model (
    output logic      sclk_o,
    output logic      chip_select_n_o,
    output logic      mosi_o,
    input  wire logic miso_i
);
    logic [7:0] rd [8];
    int         wait_ns = 160;
    // a real rising chip select clears the frame logic at start
    initial begin
        sclk_o = 1'b1;
        chip_select_n_o = 1'b0;
        mosi_o = 1'b0;
        #1 chip_select_n_o = 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic shift(input logic [7:0] d, input int k);
        for (int b = 7; b >= 0; b--) begin
            sclk_o = 1'b0;
            mosi_o = d[b];  // msb first
            #6;
            sclk_o = 1'b1;
            rd[k][b] = miso_i;
            #6;
        end
        mosi_o = ~mosi_o;  // no stale data left on a released line
    endtask : shift
    // one address byte, then n data bytes; clock idles high between frames
    task automatic access(input logic w, input logic [6:0] a,
                          input logic [7:0] wd, input int n);
        chip_select_n_o = 1'b0;
        #20;
        shift({w, a}, 0);  // direction bit above address
        #(wait_ns);  // data preparation time before first data fall
        for (int k = 0; k < n; k++)
            shift(wd, k);
        #(wait_ns);  // write must land before the frame ends
        chip_select_n_o = 1'b1;
        #(wait_ns);
    endtask : access
endmodule : msrm_host_model
`default_nettype wire

// ===== sim/msrm_register_map_properties.sv
// assertions on the register map's ports
`timescale 1ns/1ps
`default_nettype none
module msrm_register_map_properties (
    input wire logic        clk_i,
    input wire logic        resetn_i,
    input wire logic        chip_select_n_i,
    input wire logic        miso_o,
    input wire logic        frame_i,
    input wire logic [11:0] motion_dx_i,
    input wire logic [11:0] motion_dy_i,
    input wire logic        motion_flag_o,
    input wire logic        grab_restart_o,
    input wire logic [7:0]  sensor_control_o,
    input wire logic [7:0]  lamp_control_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    // cycles since the port was last selected; serial side effects
    // land a few cycles after the frame, so 8 gives margin
    logic [3:0] cs_idle;
    always_ff @(posedge clk_i) begin
        if (!resetn_i || !chip_select_n_i)
            cs_idle <= 4'h0;
        else if (cs_idle != 4'hf)
            cs_idle <= cs_idle + 4'h1;
    end
    ////////////////////////////////////////////////////////////////////////
    property p_flag_set;
        frame_i && (motion_dx_i != 12'h000 || motion_dy_i != 12'h000)
            |=> motion_flag_o;
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("motion flag not set by motion");
    property p_flag_rise;
        $rose(motion_flag_o) |-> $past(frame_i);
    endproperty
    a_flag_rise: assert property (p_flag_rise)
        else $error("motion flag rose without a frame");
    property p_flag_hold;
        $fell(motion_flag_o) |-> cs_idle < 4'h8;
    endproperty
    a_flag_hold: assert property (p_flag_hold)
        else $error("motion flag cleared without serial access");
    property p_grab_pulse;
        grab_restart_o |=> !grab_restart_o;
    endproperty
    a_grab_pulse: assert property (p_grab_pulse)
        else $error("grab restart longer than one cycle");
    property p_grab_cause;
        grab_restart_o |-> cs_idle < 4'h8;
    endproperty
    a_grab_cause: assert property (p_grab_cause)
        else $error("grab restart without serial write");
    property p_cfg_cause;
        $changed({sensor_control_o, lamp_control_o}) |-> cs_idle < 4'h8;
    endproperty
    a_cfg_cause: assert property (p_cfg_cause)
        else $error("configuration changed without serial write");
    property p_rst_vals;
        $rose(resetn_i) |-> sensor_control_o == 8'h01
            && lamp_control_o == 8'h00 && !motion_flag_o;
    endproperty
    a_rst_vals: assert property (p_rst_vals)
        else $error("wrong values after reset");
    property p_miso_idle;
        chip_select_n_i [*2] |-> !miso_o;
    endproperty
    a_miso_idle: assert property (p_miso_idle)
        else $error("serial output active while deselected");
endmodule : msrm_register_map_properties

bind msrm_register_map msrm_register_map_properties
    msrm_register_map_properties_i (
    .clk_i(clk_i), .resetn_i(resetn_i), .chip_select_n_i(chip_select_n_i),
    .miso_o(miso_o), .frame_i(frame_i), .motion_dx_i(motion_dx_i),
    .motion_dy_i(motion_dy_i), .motion_flag_o(motion_flag_o),
    .grab_restart_o(grab_restart_o), .sensor_control_o(sensor_control_o),
    .lamp_control_o(lamp_control_o));
`default_nettype wire

// ===== sim/msrm_register_map_tb.sv
// self-checking bench for the register map
`timescale 1ns/1ps
`default_nettype none
module msrm_register_map_tb;
    import msrm_pkg::*;
    localparam logic [7:0] ID_PROD = 8'h5c;  // arbitrary
    localparam logic [7:0] ID_REV  = 8'h3c;  // arbitrary
    localparam logic [14:0] ROWS [26] = '{
        {7'h00, ID_PROD}, {7'h01, ID_REV}, {7'h02, 8'h00}, {7'h03, 8'h00},
        {7'h04, 8'h00}, {7'h05, 8'h00}, {7'h06, 8'h00}, {7'h07, 8'h64},
        {7'h08, 8'hd0}, {7'h09, 8'h80}, {7'h0a, 8'h00}, {7'h0b, 8'h85},
        {7'h0c, 8'h00}, {7'h0d, 8'h01}, {7'h0e, 8'h08}, {7'h0f, 8'h01},
        {7'h10, 8'h1f}, {7'h11, 8'h09}, {7'h12, 8'h2f}, {7'h13, 8'h31},
        {7'h22, 8'h00}, {7'h3f, ~ID_REV}, {7'h40, 8'h00}, {7'h41, 8'h40},
        {7'h42, 8'h03}, {7'h14, 8'h00}};
    localparam logic [7:0] BURST [8] = '{
        8'h03, 8'h04, 8'hf0, 8'hb4, 8'h12, 8'h34, 8'h9a, 8'h77};
    localparam logic [7:0] CFG_OUT_RST [11] = '{
        8'h01, 8'h08, 8'h01, 8'h1f, 8'h09, 8'h2f, 8'h31, 8'h00, 8'h00,
        8'h40, 8'h00};
    logic              clk_i    = 1'b0;
    logic              resetn_i = 1'b1;
    logic [8:0]        feat     = 9'h1ff;
    logic [7:0]        part;
    int                n_grab   = 0;
    logic              frame    = 1'b0;
    logic [11:0]       dx       = 12'h000;
    logic [11:0]       dy       = 12'h000;
    int                errors   = 0;
    int                n_tests  = 0;
    wire               sclk, chip_select_n, mosi, miso, flag, grab;
    wire  [10:0][7:0]  cfg;
    always #12.5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        if (grab === 1'b1)
            n_grab <= n_grab + 1;
    end
    msrm_host_model host_i (.sclk_o(sclk), .chip_select_n_o(chip_select_n),
        .mosi_o(mosi), .miso_i(miso));
    msrm_register_map #(.PRODUCT_ID(ID_PROD), .REVISION_ID(ID_REV))
        msrm_register_map_i (
        .clk_i(clk_i), .resetn_i(resetn_i), .sclk_i(sclk),
        .chip_select_n_i(chip_select_n), .mosi_i(mosi), .miso_o(miso),
        .frame_i(frame), .motion_dx_i(dx), .motion_dy_i(dy),
        .surface_features_i(feat), .shutter_i(16'h1234),
        .brightest_pixel_i(8'h9a), .pixel_sum_high_i(8'h77),
        .darkest_pixel_i(8'h11), .pixel_grabber_i(8'h85),
        .motion_flag_o(flag), .grab_restart_o(grab),
        .sensor_control_o(cfg[0]), .run_idle_delay_o(cfg[1]),
        .idle1_interval_o(cfg[2]), .idle1_delay_o(cfg[3]),
        .idle2_interval_o(cfg[4]), .idle2_delay_o(cfg[5]),
        .idle3_interval_o(cfg[6]), .tuning_control_o(cfg[7]),
        .lamp_control_o(cfg[8]), .interrupt_pin_control_o(cfg[9]),
        .idle_mode_config_o(cfg[10]));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic rd(input logic [6:0] a, input logic [7:0] exp);
        host_i.access(1'b0, a, 8'h00, 1);
        check(host_i.rd[0], exp);
    endtask : rd
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        host_i.access(1'b1, a, d, 1);
    endtask : wr
    task automatic pulse(input logic [11:0] x, input logic [11:0] y);
        @(negedge clk_i);
        dx = x;
        dy = y;
        frame = 1'b1;
        @(negedge clk_i);
        frame = 1'b0;
    endtask : pulse
    task automatic give_verdict();
        $display("errors=%0d comparisons=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : give_verdict
    ////////////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        errors++;
        give_verdict();
    end
    initial begin
        // a true falling edge clears the link toggles asynchronously
        #1 resetn_i = 1'b0;
        repeat (2) @(negedge clk_i);
        resetn_i = 1'b1;
        repeat (4) @(negedge clk_i);
        foreach (ROWS[i])
            rd(ROWS[i][14:8], ROWS[i][7:0]);
        // slow host; stray writes must leave no trace
        host_i.wait_ns = 400;
        wr(7'h0d, 8'h81);
        wr(7'h07, 8'hff);
        wr(7'h15, 8'hff);
        wr(7'h0b, 8'h00);
        check(cfg[0], 8'h81);
        rd(7'h0d, 8'h81);
        rd(7'h07, 8'h64);
        rd(7'h15, 8'h00);
        rd(7'h0b, 8'h85);
        check(n_grab[7:0], 8'h01);
        host_i.wait_ns = 160;
        pulse(12'h123, 12'hffe);
        check({7'h00, flag}, 8'h01);
        rd(7'h02, 8'h80);
        rd(7'h03, 8'h23);
        rd(7'h04, 8'hfe);
        rd(7'h0c, 8'h1f);
        rd(7'h03, 8'h00);
        check({7'h00, flag}, 8'h00);
        rd(7'h05, 8'hb4);
        rd(7'h06, 8'h12);
        rd(7'h07, 8'h34);
        rd(7'h0a, 8'h11);
        // status write: data discarded, motion dropped
        pulse(12'h005, 12'h007);
        wr(7'h02, 8'hff);
        rd(7'h02, 8'h00);
        rd(7'h04, 8'h00);
        // twelve-bit burst includes the upper nibbles
        pulse(12'hf03, 12'h004);
        host_i.access(1'b0, 7'h63, 8'h00, 8);
        foreach (BURST[k])
            check(host_i.rd[k], BURST[k]);
        // motion keeps arriving while a read clears the count
        fork
            begin
                @(negedge clk_i);
                dx    = 12'h001;
                dy    = 12'h000;
                feat  = 9'h0a5;
                frame = 1'b1;
                repeat (40) @(negedge clk_i);
                frame = 1'b0;
            end
            host_i.access(1'b0, 7'h03, 8'h00, 1);
        join
        part = host_i.rd[0];
        host_i.access(1'b0, 7'h03, 8'h00, 1);
        check(part + host_i.rd[0], 8'h28);
        rd(7'h05, 8'h52);
        wr(7'h3a, 8'h5a);
        check(cfg[0], 8'h01);
        check(cfg[9], 8'h40);
        foreach (CFG_OUT_RST[i])
            check(cfg[i], CFG_OUT_RST[i]);
        // reset in mid-run returns a written register to its default
        wr(7'h40, 8'h3c);
        check(cfg[8], 8'h3c);
        @(negedge clk_i);
        resetn_i = 1'b0;
        repeat (2) @(negedge clk_i);
        resetn_i = 1'b1;
        repeat (4) @(negedge clk_i);
        check(cfg[8], 8'h00);
        rd(7'h40, 8'h00);
        give_verdict();
    end
endmodule : msrm_register_map_tb
`default_nettype wire
